// ---- verilog/nwc_pkg.sv ----
/*
 * Constants, register map, field positions and the sequencer state type
 * of the nonvolatile write control block.
 * Assumes a byte-addressed Avalon-MM slave port with 9 address bits.
 */
package nwc_pkg;
	localparam int AVS_ADDR_W = 9;
	localparam int NVM_ADDR_W = 13;
	localparam int NVM_DATA_W = 14;
	localparam int ADDR_HI_W = 5;
	localparam int DATA_HI_W = 6;

	localparam logic [8:0] OFF_ADDR_LOW = 9'h100;
	localparam logic [8:0] OFF_DATA_LOW = 9'h104;
	localparam logic [8:0] OFF_ADDR_HIGH = 9'h108;
	localparam logic [8:0] OFF_DATA_HIGH = 9'h10C;
	localparam logic [8:0] OFF_FLAG2 = 9'h110;
	localparam logic [8:0] OFF_MASK2 = 9'h114;
	localparam logic [8:0] OFF_CONTROL = 9'h18C;

	localparam int BIT_READ_GO = 0;
	localparam int BIT_WRITE_GO = 1;
	localparam int BIT_WRITE_ALLOW = 2;
	localparam int BIT_WRITE_ABORT = 3;
	localparam int BIT_SPACE_SELECT = 7;
	localparam int BIT_WRITE_DONE = 4;

	localparam logic RST_CTRL_BIT = 1'b0;
	localparam logic RST_FLAG_BIT = 1'b0;
	localparam logic RST_PIN_LEVEL = 1'b1;
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ERASE,
		SEQ_PROG,
		SEQ_READ
	} nwc_seq_state_type;

	function automatic logic nwc_hit(input logic [8:0] addr,
		input logic [8:0] off);
		nwc_hit = (addr == off);
	endfunction
endpackage

// ---- verilog/nwc_seq_if.sv ----
/*
 * Carrier between the register front end and the array sequencer.
 * Assumes both ends run on the same clock.
 */
interface nwc_seq_if;
	logic start_write;
	logic start_read;
	logic space;
	logic [12:0] addr;
	logic [13:0] wdata;
	logic abort;
	logic busy;
	logic write_done;
	logic read_done;
	logic [13:0] rdata;

	modport ctl(output start_write, output start_read, output space,
		output addr, output wdata, output abort, input busy,
		input write_done, input read_done, input rdata);
	modport seq(input start_write, input start_read, input space,
		input addr, input wdata, input abort, output busy,
		output write_done, output read_done, output rdata);
endinterface

// ---- verilog/nwc_sequencer.sv ----
/*
 * Array sequencer: erase then program for writes, single step for reads.
 * Assumes the array pulses arr_step_done_in once per finished step.
 */
module nwc_sequencer
	import nwc_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	nwc_seq_if.seq bus,
	input wire logic arr_step_done_in,
	input wire logic [13:0] arr_rdata_in,
	output logic arr_space_out,
	output logic [12:0] arr_addr_out,
	output logic [13:0] arr_wdata_out,
	output logic arr_erase_out,
	output logic arr_program_out,
	output logic arr_read_out,
	output logic core_halt_out
);
	nwc_seq_state_type state_q, state_d;
	logic [12:0] addr_q;
	logic [13:0] wdata_q;
	logic space_q;
	logic step_ok;

	assign step_ok = arr_step_done_in & ~bus.abort;

	always_comb begin
		state_d = state_q;
		case (state_q)
			SEQ_IDLE: begin
				if (bus.start_write)
					state_d = SEQ_ERASE;
				else if (bus.start_read)
					state_d = SEQ_READ;
			end
			SEQ_ERASE: begin
				if (step_ok)
					state_d = SEQ_PROG;
			end
			SEQ_PROG: begin
				if (step_ok)
					state_d = SEQ_IDLE;
			end
			SEQ_READ: begin
				if (step_ok)
					state_d = SEQ_IDLE;
			end
			default: state_d = SEQ_IDLE;
		endcase
		if (bus.abort)
			state_d = SEQ_IDLE;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_q <= SEQ_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			space_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == SEQ_IDLE && (bus.start_write || bus.start_read)) begin
				addr_q <= bus.addr;
				wdata_q <= bus.wdata;
				space_q <= bus.space;
			end
		end
	end

	assign bus.busy = (state_q != SEQ_IDLE);
	assign bus.write_done = (state_q == SEQ_PROG) & step_ok;
	assign bus.read_done = (state_q == SEQ_READ) & step_ok;
	assign bus.rdata = arr_rdata_in;
	assign arr_space_out = space_q;
	assign arr_addr_out = addr_q;
	assign arr_wdata_out = wdata_q;
	assign arr_erase_out = (state_q == SEQ_ERASE);
	assign arr_program_out = (state_q == SEQ_PROG);
	assign arr_read_out = (state_q == SEQ_READ);
	// Only program-space writes stall the core; EEPROM runs in background
	assign core_halt_out = space_q &
		(state_q == SEQ_ERASE || state_q == SEQ_PROG);

	property p_erase_before_prog;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(arr_program_out) |-> $past(arr_erase_out);
	endproperty
	a_erase_before_prog: assert property (p_erase_before_prog)
		else $error("program step not preceded by erase");

	property p_addr_held;
		@(posedge clk_in) disable iff (sys_rst_in)
		(arr_erase_out || arr_program_out) && !bus.abort
			|=> $stable(arr_addr_out) && $stable(arr_wdata_out);
	endproperty
	a_addr_held: assert property (p_addr_held)
		else $error("array address or data moved during write");
endmodule

// ---- verilog/nwc_top.sv ----
/*
 * Nonvolatile write control: Avalon-MM register front end, reset
 * handling and completion interrupt around the array sequencer.
 * Assumes a synchronous power-on reset, an asynchronous active-low
 * external reset pin and a watchdog reset pulse on the same clock.
 */
// Design decision made here: the Avalon-MM slave port.
// Overview of operation
// - No write start without write allow set
// - Write go starts write, hardware clears it
// - EEPROM write erases byte then programs data
// - EEPROM write completion sets done flag
// - Program write halts the core throughout
// - Program write erases then programs concatenated word
// - Program write done sets flag, core resumes
// - Warm reset during write sets abort flag
// - Warm reset keeps data, address, space select
// - Control low bits reset zero, abort only on power-on reset; go bits set-only
module nwc_top
	import nwc_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [8:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	input wire logic ext_reset_pin_n_in,
	input wire logic watchdog_reset_in,
	output logic core_halt_out,
	output logic arr_space_out,
	output logic [12:0] arr_addr_out,
	output logic [13:0] arr_wdata_out,
	output logic arr_erase_out,
	output logic arr_program_out,
	output logic arr_read_out,
	input wire logic arr_step_done_in,
	input wire logic [13:0] arr_rdata_in
);
	nwc_seq_if seq_bus();

	logic pin_s1_q, pin_s2_q, pin_s3_q, pin_level_q;
	logic warm;
	logic space_q, space_d;
	logic abort_q, abort_d;
	logic allow_q, allow_d;
	logic wgo_q, wgo_d;
	logic rgo_q, rgo_d;
	logic done_q, done_d;
	logic mask_q, mask_d;
	logic [7:0] addr_lo_q, addr_lo_d;
	logic [ADDR_HI_W-1:0] addr_hi_q, addr_hi_d;
	logic [7:0] data_lo_q, data_lo_d;
	logic [DATA_HI_W-1:0] data_hi_q, data_hi_d;
	logic rd_ack_q;
	logic [31:0] readdata_q;
	logic wr_ok, idle;
	logic ctrl_wr, flag_wr, mask_wr;
	logic addr_lo_wr, addr_hi_wr, data_lo_wr, data_hi_wr;
	logic start_write, start_read;
	logic [7:0] ctrl_val, flag_val, mask_val, rd_byte;
	logic [7:0] wbyte;

	// Pin is asynchronous; only the agreeing later stages are trusted
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pin_s1_q <= RST_PIN_LEVEL;
			pin_s2_q <= RST_PIN_LEVEL;
			pin_s3_q <= RST_PIN_LEVEL;
			pin_level_q <= RST_PIN_LEVEL;
		end else begin
			pin_s1_q <= ext_reset_pin_n_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q)
				pin_level_q <= pin_s3_q;
		end
	end

	assign warm = ~pin_level_q | watchdog_reset_in;

	assign wbyte = avs_writedata_in[7:0];
	assign wr_ok = avs_write_in & avs_byteenable_in[0];
	assign ctrl_wr = wr_ok & nwc_hit(avs_address_in, OFF_CONTROL);
	assign flag_wr = wr_ok & nwc_hit(avs_address_in, OFF_FLAG2);
	assign mask_wr = wr_ok & nwc_hit(avs_address_in, OFF_MASK2);
	assign addr_lo_wr = wr_ok & nwc_hit(avs_address_in, OFF_ADDR_LOW);
	assign addr_hi_wr = wr_ok & nwc_hit(avs_address_in, OFF_ADDR_HIGH);
	assign data_lo_wr = wr_ok & nwc_hit(avs_address_in, OFF_DATA_LOW);
	assign data_hi_wr = wr_ok & nwc_hit(avs_address_in, OFF_DATA_HIGH);

	// Operands and space select are frozen while any access runs
	assign idle = ~seq_bus.busy & ~wgo_q & ~rgo_q & ~warm;

	assign start_write = ctrl_wr & wbyte[BIT_WRITE_GO] & allow_q & idle;
	assign start_read = ctrl_wr & wbyte[BIT_READ_GO] & ~start_write & idle;

	// Go bits: software can only set, hardware clears on completion
	assign wgo_d = warm ? RST_CTRL_BIT : start_write ? 1'b1 :
		seq_bus.write_done ? 1'b0 : wgo_q;
	assign rgo_d = warm ? RST_CTRL_BIT : start_read ? 1'b1 :
		seq_bus.read_done ? 1'b0 : rgo_q;
	assign allow_d = warm ? RST_CTRL_BIT :
		ctrl_wr ? wbyte[BIT_WRITE_ALLOW] : allow_q;
	// Abort set beats a software write in the same cycle
	assign abort_d = (warm & seq_bus.busy & wgo_q) ? 1'b1 :
		ctrl_wr ? wbyte[BIT_WRITE_ABORT] : abort_q;
	assign space_d = (ctrl_wr & idle) ?
		wbyte[BIT_SPACE_SELECT] : space_q;

	// Completion set wins over a write-one-to-clear in the same cycle
	assign done_d = warm ? RST_FLAG_BIT : seq_bus.write_done ? 1'b1 :
		(flag_wr & wbyte[BIT_WRITE_DONE]) ? 1'b0 : done_q;
	assign mask_d = warm ? RST_FLAG_BIT :
		mask_wr ? wbyte[BIT_WRITE_DONE] : mask_q;

	// No warm-reset term: operands survive pin and watchdog resets
	assign addr_lo_d = (addr_lo_wr & idle) ? wbyte : addr_lo_q;
	assign addr_hi_d = (addr_hi_wr & idle) ?
		wbyte[ADDR_HI_W-1:0] : addr_hi_q;
	assign data_lo_d = seq_bus.read_done ? seq_bus.rdata[7:0] :
		(data_lo_wr & idle) ? wbyte : data_lo_q;
	assign data_hi_d = seq_bus.read_done ?
		seq_bus.rdata[NVM_DATA_W-1:8] :
		(data_hi_wr & idle) ? wbyte[DATA_HI_W-1:0] : data_hi_q;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			space_q <= RST_CTRL_BIT;
			abort_q <= RST_CTRL_BIT;
			allow_q <= RST_CTRL_BIT;
			wgo_q <= RST_CTRL_BIT;
			rgo_q <= RST_CTRL_BIT;
			done_q <= RST_FLAG_BIT;
			mask_q <= RST_FLAG_BIT;
			addr_lo_q <= RST_BYTE;
			addr_hi_q <= RST_BYTE[ADDR_HI_W-1:0];
			data_lo_q <= RST_BYTE;
			data_hi_q <= RST_BYTE[DATA_HI_W-1:0];
		end else begin
			space_q <= space_d;
			abort_q <= abort_d;
			allow_q <= allow_d;
			wgo_q <= wgo_d;
			rgo_q <= rgo_d;
			done_q <= done_d;
			mask_q <= mask_d;
			addr_lo_q <= addr_lo_d;
			addr_hi_q <= addr_hi_d;
			data_lo_q <= data_lo_d;
			data_hi_q <= data_hi_d;
		end
	end

	assign seq_bus.start_write = start_write;
	assign seq_bus.start_read = start_read;
	assign seq_bus.space = space_d;
	assign seq_bus.addr = {addr_hi_q, addr_lo_q};
	assign seq_bus.wdata = {data_hi_q, data_lo_q};
	assign seq_bus.abort = warm;

	nwc_sequencer u_seq (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.bus(seq_bus),
		.arr_step_done_in(arr_step_done_in),
		.arr_rdata_in(arr_rdata_in),
		.arr_space_out(arr_space_out),
		.arr_addr_out(arr_addr_out),
		.arr_wdata_out(arr_wdata_out),
		.arr_erase_out(arr_erase_out),
		.arr_program_out(arr_program_out),
		.arr_read_out(arr_read_out),
		.core_halt_out(core_halt_out)
	);

	// Bits 6 to 4 of control read as zero
	assign ctrl_val = {space_q, 3'h0, abort_q, allow_q, wgo_q, rgo_q};
	assign flag_val = {3'h0, done_q, 4'h0};
	assign mask_val = {3'h0, mask_q, 4'h0};
	assign rd_byte = nwc_hit(avs_address_in, OFF_CONTROL) ? ctrl_val :
		nwc_hit(avs_address_in, OFF_FLAG2) ? flag_val :
		nwc_hit(avs_address_in, OFF_MASK2) ? mask_val :
		nwc_hit(avs_address_in, OFF_ADDR_LOW) ? addr_lo_q :
		nwc_hit(avs_address_in, OFF_ADDR_HIGH) ? {3'h0, addr_hi_q} :
		nwc_hit(avs_address_in, OFF_DATA_LOW) ? data_lo_q :
		nwc_hit(avs_address_in, OFF_DATA_HIGH) ? {2'h0, data_hi_q} :
		8'h00;

	// One wait state on reads buys registered read data
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_ack_q <= 1'b0;
			readdata_q <= 32'h00000000;
		end else begin
			rd_ack_q <= avs_read_in & ~rd_ack_q;
			if (avs_read_in & ~rd_ack_q)
				readdata_q <= {24'h000000, rd_byte};
		end
	end

	assign avs_waitrequest_out = avs_read_in & ~rd_ack_q;
	assign avs_readdata_out = readdata_q;
	assign irq_out = done_q & mask_q;

	property p_allow_needed;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(wgo_q) |-> $past(allow_q);
	endproperty
	a_allow_needed: assert property (p_allow_needed)
		else $error("write started without write allow");

	property p_go_self_clear;
		@(posedge clk_in) disable iff (sys_rst_in)
		seq_bus.write_done |=> !wgo_q && done_q;
	endproperty
	a_go_self_clear: assert property (p_go_self_clear)
		else $error("write go or done flag wrong after completion");

	property p_eeprom_background;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		start_write && !space_d |=> !core_halt_out;
	endproperty
	a_eeprom_background: assert property (p_eeprom_background)
		else $error("data EEPROM write stalled the core");

	property p_done_irq;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		seq_bus.write_done && mask_d |=> irq_out;
	endproperty
	a_done_irq: assert property (p_done_irq)
		else $error("completion did not raise the interrupt");

	property p_prog_halt;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		start_write && space_d |=> core_halt_out [*2];
	endproperty
	a_prog_halt: assert property (p_prog_halt)
		else $error("program write did not halt the core");

	property p_resume;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		seq_bus.write_done |=> !core_halt_out && done_q;
	endproperty
	a_resume: assert property (p_resume)
		else $error("core not resumed after program write");

	property p_abort_flag;
		@(posedge clk_in) disable iff (sys_rst_in)
		warm && seq_bus.busy && wgo_q |=> abort_q && !wgo_q;
	endproperty
	a_abort_flag: assert property (p_abort_flag)
		else $error("interrupted write did not set abort flag");

	property p_warm_keeps;
		@(posedge clk_in) disable iff (sys_rst_in)
		warm |=> $stable(addr_lo_q) && $stable(data_lo_q) &&
			$stable(space_q) && $stable(addr_hi_q);
	endproperty
	a_warm_keeps: assert property (p_warm_keeps)
		else $error("warm reset changed operand registers");

	property p_go_set_only;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		wgo_q && !seq_bus.write_done |=> wgo_q;
	endproperty
	a_go_set_only: assert property (p_go_set_only)
		else $error("write go cleared without completion");

	property p_space_frozen;
		@(posedge clk_in) disable iff (sys_rst_in)
		seq_bus.busy |=> $stable(space_q);
	endproperty
	a_space_frozen: assert property (p_space_frozen)
		else $error("space select changed while busy");

	property p_read_load;
		@(posedge clk_in) disable iff (sys_rst_in || warm)
		seq_bus.read_done |=> !rgo_q &&
			data_lo_q == $past(arr_rdata_in[7:0]);
	endproperty
	a_read_load: assert property (p_read_load)
		else $error("read did not load data or clear read go");
endmodule

// ---- tb/nwc_array_model.sv ----
/*
 * Behavioural model of the data EEPROM and program flash arrays.
 * Assumes the sequencer holds one strobe until step_done answers it.
 */
module nwc_array_model (
	input wire logic clk_in,
	input wire logic [7:0] delay_in,
	input wire logic space_in,
	input wire logic [12:0] addr_in,
	input wire logic [13:0] wdata_in,
	input wire logic erase_in,
	input wire logic program_in,
	input wire logic read_in,
	output logic step_done_out,
	output logic [13:0] rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [13:0] mem [logic [13:0]];
	logic [7:0] cnt;
	logic [13:0] key;
	logic [13:0] old;
	assign key = {space_in, addr_in};
	assign old = mem.exists(key) ? mem[key] : 14'h0000;
	initial begin
		step_done_out = 1'b0;
		rdata_out = 14'h1555;
		cnt = 8'h00;
	end
	always @(posedge clk_in) begin
		step_done_out <= 1'b0;
		// Idle bus toggles so stale data never looks valid
		rdata_out <= ~rdata_out;
		if (step_done_out || !(erase_in || program_in || read_in)) begin
			cnt <= 8'h00;
		end else if (cnt < delay_in) begin
			cnt <= cnt + 8'h01;
		end else begin
			step_done_out <= 1'b1;
			if (erase_in) begin
				mem[key] = 14'h3FFF;
			end
			// Program only clears bits: skipping the erase shows up
			if (program_in) begin
				mem[key] = old & wdata_in;
			end
			if (read_in) begin
				rdata_out <= old;
			end
		end
	end
endmodule

// ---- tb/nwc_top_tb.sv ----
/*
 * Register-level testbench of the nonvolatile write control block.
 * Assumes the array model answers each step delay plus one cycles after its strobe.
 */
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end \
end
module nwc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import nwc_pkg::*;
	logic clk_in, sys_rst_in, avs_read_in, avs_write_in;
	logic [8:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic avs_waitrequest_out, irq_out, ext_reset_pin_n_in;
	logic watchdog_reset_in, core_halt_out, arr_space_out;
	logic [12:0] arr_addr_out;
	logic [13:0] arr_wdata_out, arr_rdata_in;
	logic arr_erase_out, arr_program_out, arr_read_out, arr_step_done_in;
	logic [7:0] dly;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	nwc_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
		.ext_reset_pin_n_in(ext_reset_pin_n_in),
		.watchdog_reset_in(watchdog_reset_in),
		.core_halt_out(core_halt_out), .arr_space_out(arr_space_out),
		.arr_addr_out(arr_addr_out), .arr_wdata_out(arr_wdata_out),
		.arr_erase_out(arr_erase_out), .arr_program_out(arr_program_out),
		.arr_read_out(arr_read_out), .arr_step_done_in(arr_step_done_in),
		.arr_rdata_in(arr_rdata_in));
	nwc_array_model arr_model (.clk_in(clk_in), .delay_in(dly),
		.space_in(arr_space_out), .addr_in(arr_addr_out),
		.wdata_in(arr_wdata_out), .erase_in(arr_erase_out),
		.program_in(arr_program_out), .read_in(arr_read_out),
		.step_done_out(arr_step_done_in), .rdata_out(arr_rdata_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task finish_test;
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Bounded run; a hung handshake ends here
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic [8:0] a, input logic rd,
		input logic [7:0] wd, output logic [31:0] q);
		avs_address_in <= a;
		avs_read_in <= rd;
		avs_write_in <= !rd;
		avs_writedata_in <= {24'h000000, wd};
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		// Read data taken at the same edge as the answer
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'b0, d, q);
	endtask
	task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b1, 8'h00, q);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	task automatic wait_go(input logic [7:0] m);
		logic [31:0] q;
		int k;
		k = 0;
		do begin
			bus(OFF_CONTROL, 1'b1, 8'h00, q);
			k++;
		end while ((q[7:0] & m) != 8'h00 && k < 200);
		`CHK("go bits", 8'h00, q[7:0] & m)
	endtask
	initial begin
		sys_rst_in = 1'b1;
		avs_address_in = 9'h000;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h00000000;
		ext_reset_pin_n_in = 1'b1;
		watchdog_reset_in = 1'b0;
		dly = 8'h10;
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		rd_chk(OFF_CONTROL, 32'h00);
		rd_chk(OFF_FLAG2, 32'h00);
		rd_chk(OFF_MASK2, 32'h00);
		rd_chk(9'h000, 32'h00);
		wr(OFF_CONTROL, 8'h02);
		repeat (4) @(posedge clk_in);
		`CHK("erase", 1'b0, arr_erase_out)
		rd_chk(OFF_CONTROL, 32'h00);
		wr(OFF_CONTROL, 8'h76);
		rd_chk(OFF_CONTROL, 32'h04);
		// Data EEPROM write, slow array
		wr(OFF_ADDR_LOW, 8'h15);
		wr(OFF_DATA_LOW, 8'hA5);
		wr(OFF_FLAG2, 8'h10);
		wr(OFF_CONTROL, 8'h06);
		@(negedge clk_in);
		`CHK("erase", 1'b1, arr_erase_out)
		`CHK("halt", 1'b0, core_halt_out)
		`CHK("addr", 13'h0015, arr_addr_out)
		rd_chk(OFF_CONTROL, 32'h06);
		wr(OFF_CONTROL, 8'h04);
		rd_chk(OFF_CONTROL, 32'h06);
		wait_go(8'h02);
		rd_chk(OFF_CONTROL, 32'h04);
		`CHK("irq", 1'b0, irq_out)
		rd_chk(OFF_FLAG2, 32'h10);
		wr(OFF_MASK2, 8'h10);
		`CHK("irq", 1'b1, irq_out)
		wr(OFF_FLAG2, 8'h10);
		`CHK("irq", 1'b0, irq_out)
		rd_chk(OFF_FLAG2, 32'h00);
		`CHK("cell", 14'h00A5, arr_model.mem[14'h0015])
		// Program flash write; refused updates while busy
		dly <= 8'h08;
		wr(OFF_ADDR_HIGH, 8'h1F);
		wr(OFF_ADDR_LOW, 8'h3C);
		wr(OFF_DATA_HIGH, 8'h2B);
		wr(OFF_DATA_LOW, 8'h5A);
		wr(OFF_CONTROL, 8'h84);
		wr(OFF_CONTROL, 8'h86);
		wr(OFF_ADDR_LOW, 8'h00);
		wr(OFF_CONTROL, 8'h04);
		n = 0;
		@(negedge clk_in);
		while ((arr_erase_out | arr_program_out) === 1'b1 && n < 500) begin
			`CHK("halt", 1'b1, core_halt_out)
			n++;
			@(negedge clk_in);
		end
		`CHK("busy seen", 1'b1, n > 0)
		`CHK("halt", 1'b0, core_halt_out)
		`CHK("irq", 1'b1, irq_out)
		rd_chk(OFF_FLAG2, 32'h10);
		`CHK("cell", 14'h2B5A, arr_model.mem[14'h3F3C])
		rd_chk(OFF_ADDR_LOW, 32'h3C);
		rd_chk(OFF_CONTROL, 32'h84);
		wr(OFF_FLAG2, 8'h10);
		// Reads of both spaces, prompt array
		dly <= 8'h00;
		wr(OFF_DATA_LOW, 8'h00);
		wr(OFF_DATA_HIGH, 8'h00);
		wr(OFF_CONTROL, 8'h81);
		wait_go(8'h01);
		rd_chk(OFF_CONTROL, 32'h80);
		rd_chk(OFF_DATA_LOW, 32'h5A);
		rd_chk(OFF_DATA_HIGH, 32'h2B);
		wr(OFF_ADDR_HIGH, 8'h00);
		wr(OFF_ADDR_LOW, 8'h15);
		wr(OFF_CONTROL, 8'h01);
		wait_go(8'h01);
		rd_chk(OFF_DATA_LOW, 32'hA5);
		rd_chk(OFF_DATA_HIGH, 32'h00);
		// Watchdog reset in mid-erase
		dly <= 8'h28;
		wr(OFF_ADDR_LOW, 8'h22);
		wr(OFF_DATA_LOW, 8'h77);
		wr(OFF_CONTROL, 8'h04);
		wr(OFF_CONTROL, 8'h06);
		repeat (3) @(posedge clk_in);
		watchdog_reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		watchdog_reset_in <= 1'b0;
		@(posedge clk_in);
		`CHK("erase", 1'b0, arr_erase_out)
		rd_chk(OFF_CONTROL, 32'h08);
		rd_chk(OFF_ADDR_LOW, 32'h22);
		rd_chk(OFF_DATA_LOW, 32'h77);
		wr(OFF_CONTROL, 8'h00);
		rd_chk(OFF_CONTROL, 32'h00);
		// External pin reset during a flash write
		wr(OFF_CONTROL, 8'h84);
		wr(OFF_CONTROL, 8'h86);
		repeat (3) @(posedge clk_in);
		ext_reset_pin_n_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		ext_reset_pin_n_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		`CHK("halt", 1'b0, core_halt_out)
		rd_chk(OFF_CONTROL, 32'h88);
		rd_chk(OFF_ADDR_LOW, 32'h22);
		rd_chk(OFF_MASK2, 32'h00);
		finish_test();
	end
endmodule
